// ---- logic/obhd_map.svh ----
// Word indices, field positions and codes of the boot header decoder.
// Assumes word-wide access to the one-time store, one word per index.
`ifndef OBHD_MAP_SVH
`define OBHD_MAP_SVH

// ------------------------------------------------------------
// Store geometry
// ------------------------------------------------------------
`define OBHD_DEPTH_WORDS   14'h2000
`define OBHD_VECTOR_BASE   13'h0000
`define OBHD_VECTOR_WORDS  14'h0020
`define OBHD_SCRIPT_WORDS  14'h003C
`define OBHD_HDR_WORDS     14'h0010
`define OBHD_HDR_BASE      13'h1FF0

// ------------------------------------------------------------
// Header word offsets, reserved words 11..15 are never read
// ------------------------------------------------------------
`define OBHD_W_FLAG1       4'h0
`define OBHD_W_FLAG2       4'h1
`define OBHD_W_BOOTCFG     4'h2
`define OBHD_W_PINMAP      4'h3
`define OBHD_W_PKG         4'h4
`define OBHD_W_ADDR_LO     4'h5
`define OBHD_W_ADDR_HI     4'h6
`define OBHD_W_COPYLEN     4'h7
`define OBHD_W_POS         4'h8
`define OBHD_W_TEST        4'h9
`define OBHD_W_STAMP       4'hA
`define OBHD_READ_WORDS    4'hB

// ------------------------------------------------------------
// Codes
// ------------------------------------------------------------
`define OBHD_FLAG1_VALID   32'h1234_A5A5
`define OBHD_FLAG2_VALID   32'hA5A5_1234
`define OBHD_BOOT_SPI      8'hAA
`define OBHD_BOOT_NORMAL   8'hFF
`define OBHD_UNPROG_BYTE   8'hFF
`define OBHD_WAKE_DEFAULT  8'hAB
`define OBHD_UART_L3       8'h01
`define OBHD_UART_L5       8'h02
`define OBHD_PKG_WL_L5     8'hFF
`define OBHD_PKG_WL_NO_L5  8'h66
`define OBHD_PKG_QFN       8'hAA
`define OBHD_ERASED_WORD   28'hFFF_FFFF
`define OBHD_CS_PULSE      4'h4

`endif

// ---- logic/obhd_pkg.sv ----
// Types shared by the boot header decoder and its flash wake sequencer.
// Assumes the map header supplies all numeric constants.
package obhd_pkg;

  typedef enum logic [1:0] {
    OBHD_UART_TWO_WIRE,
    OBHD_UART_ONE_WIRE_L3,
    OBHD_UART_ONE_WIRE_L5
  } obhd_uart_t;

  typedef enum logic [1:0] {
    OBHD_PKG_WAFER_L5,
    OBHD_PKG_WAFER_NO_L5,
    OBHD_PKG_QUAD_FLAT,
    OBHD_PKG_OTHER
  } obhd_pkg_t;

  typedef enum {
    OBHD_ST_IDLE,
    OBHD_ST_REQ,
    OBHD_ST_WAIT,
    OBHD_ST_WAKE,
    OBHD_ST_DONE
  } obhd_state_t;

  typedef enum {
    OBHD_WK_IDLE,
    OBHD_WK_SHIFT,
    OBHD_WK_CS,
    OBHD_WK_END
  } obhd_wake_t;

endpackage : obhd_pkg

// ---- logic/obhd_flash_wake.sv ----
// Flash wake sequencer: one opcode byte over a serial port, or a select pulse.
// Assumes an active-low reset, applied asynchronously and released in step with the clock by the parent.
`timescale 1ns/1ns
`include "obhd_map.svh"

module obhd_flash_wake
  import obhd_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic       i_use_cs,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_div,
  output logic            o_done,
  // Serial lines
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic            o_mosi
);

  obhd_wake_t st_reg, st_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       sclk_reg, sclk_next;
  logic       cs_n_reg, cs_n_next;
  logic       tick;

  // ------------------------------------------------------------
  // Rate divider, one half serial period per tick
  // ------------------------------------------------------------
  assign tick = (div_reg == 8'h00);

  always_comb begin
    st_next   = st_reg;
    div_next  = tick ? i_div : div_reg - 8'h01;
    sh_next   = sh_reg;
    cnt_next  = cnt_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    case (st_reg)
      OBHD_WK_IDLE: begin
        if (i_start) begin
          div_next  = i_div;
          sh_next   = i_opcode;
          cnt_next  = 4'h0;
          cs_n_next = 1'b0;
          // RL22 select toggle wake
          st_next   = i_use_cs ? OBHD_WK_CS : OBHD_WK_SHIFT;
        end
      end
      OBHD_WK_SHIFT: begin
        // RL21 opcode shifted MSB first
        if (tick) begin
          sclk_next = ~sclk_reg;
          if (sclk_reg) begin
            sh_next  = {sh_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h7) begin
              st_next = OBHD_WK_END;
            end
          end
        end
      end
      OBHD_WK_CS: begin
        if (tick) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `OBHD_CS_PULSE) begin
            st_next = OBHD_WK_END;
          end
        end
      end
      OBHD_WK_END: begin
        if (tick) begin
          cs_n_next = 1'b1;
          st_next   = OBHD_WK_IDLE;
        end
      end
      default: st_next = OBHD_WK_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg   <= OBHD_WK_IDLE;
      div_reg  <= 8'h00;
      sh_reg   <= 8'h00;
      cnt_reg  <= 4'h0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      sh_reg   <= sh_next;
      cnt_reg  <= cnt_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
    end
  end

  assign o_sclk = sclk_reg;
  assign o_cs_n = cs_n_reg;
  assign o_mosi = sh_reg[7];
  assign o_done = (st_reg == OBHD_WK_END) && tick;

endmodule : obhd_flash_wake

// ---- logic/obhd_decoder.sv ----
// Boot header decoder: reads the header words of the one-time store and decodes them.
// Assumes a same-clock word read port answering with one valid pulse per request.
// How it works
// RL1: Store is 8K words of 32 bits, read one word per address.
// RL2: Vector list fills the first 32 words from address zero, part of image.
// RL3: Configuration script region holds up to 60 words.
// RL4: Header region spans exactly 16 words at the top of the store.
// RL5: First present flag valid only when it equals 1234A5A5.
// RL6: Second present flag valid only when it equals A5A51234.
// RL7: Normal mode needs both flags valid, else development mode.
// RL8: Boot byte AA means serial port boot, FF means normal sequence.
// RL9: Wake opcode from bits 15..8, serial divisor from bits 23..16.
// RL10: Top byte picks boot UART pins; unknown values give two-wire.
// RL11: Pin map word gives four signals, port upper nibble, pin lower.
// RL12: Package word: package code low byte, device code next, rest reserved.
// RL13: Two words hold the 64-bit radio address as a byte string.
// RL14: Copy length word counts 32-bit words.
// RL15: Position word packs X, Y, wafer and batch bytes.
// RL16: Test word holds site, station identity low and high, reserved top.
// RL17: Time stamp word holds four stamp bytes, byte zero lowest.
// RL18: Five reserved header words are never read nor used.
// RL19: Unprogrammed package word reads as all ones; the code flags it when bits 27..0 are all ones, whatever the top nibble.
// RL20: Serial boot selected: apply pin map, probe no other interface.
// RL21: Wake flash with configured opcode, AB when unprogrammed.
// RL22: Flash may instead be woken by toggling chip select.
// RL23: Unknown boot byte falls back to the normal sequence.
`timescale 1ns/1ns
`include "obhd_map.svh"

module obhd_decoder
  import obhd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Store read port
  output logic             o_otp_rd,
  output logic [12:0]      o_otp_addr,
  input  wire logic        i_otp_valid,
  input  wire logic [31:0] i_otp_data,
  // Control
  input  wire logic        i_wake_use_cs,
  output logic             o_done,
  // Boot decisions
  output logic             o_normal_mode,
  output logic             o_dev_mode,
  output logic             o_spi_boot,
  output logic             o_probe_others,
  output obhd_uart_t       o_uart_sel,
  output logic [7:0]       o_wake_opcode,
  output logic [7:0]       o_spi_div,
  output logic [3:0]       o_clk_port,
  output logic [3:0]       o_clk_pin,
  output logic [3:0]       o_sel_port,
  output logic [3:0]       o_sel_pin,
  output logic [3:0]       o_dout_port,
  output logic [3:0]       o_dout_pin,
  output logic [3:0]       o_boot_data_in_pin_port,
  output logic [3:0]       o_boot_data_in_pin,
  // Identity and trace
  output obhd_pkg_t        o_pkg_type,
  output logic [7:0]       o_device_code,
  output logic             o_pkg_unprog,
  output logic [63:0]      o_radio_addr,
  output logic [31:0]      o_copy_len,
  output logic             o_copy_len_ok,
  output logic [7:0]       o_die_x,
  output logic [7:0]       o_die_y,
  output logic [7:0]       o_wafer,
  output logic [7:0]       o_production_batch,
  output logic [7:0]       o_test_site,
  output logic [15:0]      o_test_station_ident,
  output logic [31:0]      o_stamp,
  // Flash wake lines
  output logic             o_spi_sclk,
  output logic             o_spi_cs_n,
  output logic             o_spi_mosi
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_a_reg;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_a_reg <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n     <= rst_a_reg;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] hi_nib(input logic [7:0] b);
    hi_nib = b[7:4];
  endfunction : hi_nib

  function automatic logic [3:0] lo_nib(input logic [7:0] b);
    lo_nib = b[3:0];
  endfunction : lo_nib

  // ------------------------------------------------------------
  // Header fetch
  // ------------------------------------------------------------
  obhd_state_t st_reg, st_next;
  logic [3:0]  idx_reg, idx_next;
  logic [31:0] hdr_reg [0:10];
  logic        wake_start;
  logic        wake_done;

  always_comb begin
    st_next    = st_reg;
    idx_next   = idx_reg;
    wake_start = 1'b0;
    case (st_reg)
      OBHD_ST_IDLE: st_next = OBHD_ST_REQ;
      OBHD_ST_REQ:  st_next = OBHD_ST_WAIT;
      OBHD_ST_WAIT: begin
        if (i_otp_valid) begin
          idx_next = idx_reg + 4'h1;
          // RL18 stop before reserved words
          if (idx_reg == `OBHD_READ_WORDS - 4'h1) begin
            // RL20 wake only on serial boot
            wake_start = o_spi_boot;
            st_next    = o_spi_boot ? OBHD_ST_WAKE : OBHD_ST_DONE;
          end else begin
            st_next = OBHD_ST_REQ;
          end
        end
      end
      OBHD_ST_WAKE: begin
        if (wake_done) begin
          st_next = OBHD_ST_DONE;
        end
      end
      OBHD_ST_DONE: st_next = OBHD_ST_DONE;
      default:      st_next = OBHD_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg  <= OBHD_ST_IDLE;
      idx_reg <= 4'h0;
    end else begin
      st_reg  <= st_next;
      idx_reg <= idx_next;
    end
  end

  // Header words keep no reset: decisions latch them only on the last word, but o_spi_div and the early o_spi_boot read them before they are fetched
  always_ff @(posedge i_clock) begin
    if (st_reg == OBHD_ST_WAIT && i_otp_valid) begin
      hdr_reg[idx_reg] <= i_otp_data;
    end
  end

  // RL1 word addressing
  // RL4 header at the top
  assign o_otp_rd   = (st_reg == OBHD_ST_REQ);
  assign o_otp_addr = `OBHD_HDR_BASE + {9'h000, idx_reg};
  assign o_done     = (st_reg == OBHD_ST_DONE);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [7:0] boot_byte;
  logic [7:0] uart_byte;
  logic [7:0] pkg_byte;
  logic [7:0] op_byte;
  logic [31:0] pmap;
  logic       flags_ok;
  logic       copy_ok;

  assign boot_byte = hdr_reg[`OBHD_W_BOOTCFG][7:0];
  assign uart_byte = hdr_reg[`OBHD_W_BOOTCFG][31:24];
  assign op_byte   = hdr_reg[`OBHD_W_BOOTCFG][15:8];
  assign pkg_byte  = hdr_reg[`OBHD_W_PKG][7:0];
  assign pmap      = hdr_reg[`OBHD_W_PINMAP];

  // RL5 first flag
  // RL6 second flag
  // RL7 both flags needed
  assign flags_ok = (hdr_reg[`OBHD_W_FLAG1] == `OBHD_FLAG1_VALID) &&
                    (hdr_reg[`OBHD_W_FLAG2] == `OBHD_FLAG2_VALID);

  // RL2 image covers vectors
  // RL3 script room kept free
  assign copy_ok = ({14'h0000, hdr_reg[`OBHD_W_COPYLEN][17:0]} >= {18'h0, `OBHD_VECTOR_WORDS})
                && (hdr_reg[`OBHD_W_COPYLEN][31:18] == 14'h0000)
                && (hdr_reg[`OBHD_W_COPYLEN][17:0] <=
                    {4'h0, `OBHD_DEPTH_WORDS - `OBHD_HDR_WORDS - `OBHD_SCRIPT_WORDS});

  logic       normal_reg, spi_reg, pkg_unprog_reg, copy_ok_reg;
  logic [7:0] wake_op_reg;
  obhd_uart_t uart_reg;
  obhd_pkg_t  pkg_reg;

  // Decisions latch on the last header word so they stay put during wake
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      normal_reg     <= 1'b0;
      spi_reg        <= 1'b0;
      uart_reg       <= OBHD_UART_TWO_WIRE;
      wake_op_reg    <= `OBHD_WAKE_DEFAULT;
      pkg_reg        <= OBHD_PKG_OTHER;
      pkg_unprog_reg <= 1'b0;
      copy_ok_reg    <= 1'b0;
    end else if (st_reg == OBHD_ST_WAIT && i_otp_valid &&
                 idx_reg == `OBHD_READ_WORDS - 4'h1) begin
      normal_reg     <= flags_ok;
      // RL8 serial boot code
      // RL23 unknown means normal
      spi_reg        <= (boot_byte == `OBHD_BOOT_SPI);
      // RL10 boot UART pins
      case (uart_byte)
        `OBHD_UART_L3: uart_reg <= OBHD_UART_ONE_WIRE_L3;
        `OBHD_UART_L5: uart_reg <= OBHD_UART_ONE_WIRE_L5;
        default:       uart_reg <= OBHD_UART_TWO_WIRE;
      endcase
      // RL21 default wake opcode
      wake_op_reg    <= (op_byte == `OBHD_UNPROG_BYTE) ? `OBHD_WAKE_DEFAULT : op_byte;
      // RL12 package code
      case (pkg_byte)
        `OBHD_PKG_WL_L5:    pkg_reg <= OBHD_PKG_WAFER_L5;
        `OBHD_PKG_WL_NO_L5: pkg_reg <= OBHD_PKG_WAFER_NO_L5;
        `OBHD_PKG_QFN:      pkg_reg <= OBHD_PKG_QUAD_FLAT;
        default:            pkg_reg <= OBHD_PKG_OTHER;
      endcase
      // RL19 erased package word
      pkg_unprog_reg <= (hdr_reg[`OBHD_W_PKG][27:0] == `OBHD_ERASED_WORD);
      copy_ok_reg    <= copy_ok;
    end
  end

  // Early decode so the fetch state machine sees serial boot on the last word
  assign o_spi_boot = (st_reg == OBHD_ST_WAIT) ? (boot_byte == `OBHD_BOOT_SPI) : spi_reg;

  assign o_normal_mode  = normal_reg;
  assign o_dev_mode     = o_done && !normal_reg;
  // RL20 no other probing
  assign o_probe_others = o_done && !spi_reg;
  assign o_uart_sel     = uart_reg;
  assign o_wake_opcode  = wake_op_reg;
  // RL9 divisor field
  assign o_spi_div      = hdr_reg[`OBHD_W_BOOTCFG][23:16];

  // RL11 pin map nibbles
  assign o_clk_port              = hi_nib(pmap[7:0]);
  assign o_clk_pin               = lo_nib(pmap[7:0]);
  assign o_sel_port              = hi_nib(pmap[15:8]);
  assign o_sel_pin               = lo_nib(pmap[15:8]);
  assign o_dout_port             = hi_nib(pmap[23:16]);
  assign o_dout_pin              = lo_nib(pmap[23:16]);
  assign o_boot_data_in_pin_port = hi_nib(pmap[31:24]);
  assign o_boot_data_in_pin      = lo_nib(pmap[31:24]);

  assign o_pkg_type    = pkg_reg;
  assign o_device_code = hdr_reg[`OBHD_W_PKG][15:8];
  assign o_pkg_unprog  = pkg_unprog_reg;
  // RL13 byte string, byte zero lowest
  assign o_radio_addr  = {hdr_reg[`OBHD_W_ADDR_HI], hdr_reg[`OBHD_W_ADDR_LO]};
  // RL14 length in words
  assign o_copy_len    = hdr_reg[`OBHD_W_COPYLEN];
  assign o_copy_len_ok = copy_ok_reg;
  // RL15 position fields
  assign o_die_x            = hdr_reg[`OBHD_W_POS][7:0];
  assign o_die_y            = hdr_reg[`OBHD_W_POS][15:8];
  assign o_wafer            = hdr_reg[`OBHD_W_POS][23:16];
  assign o_production_batch = hdr_reg[`OBHD_W_POS][31:24];
  // RL16 test station fields
  assign o_test_site          = hdr_reg[`OBHD_W_TEST][7:0];
  assign o_test_station_ident = hdr_reg[`OBHD_W_TEST][23:8];
  // RL17 time stamp bytes
  assign o_stamp = hdr_reg[`OBHD_W_STAMP];

  // ------------------------------------------------------------
  // Flash wake
  // ------------------------------------------------------------
  obhd_flash_wake u_wake (
    .i_clock  (i_clock),
    .i_rst_n  (rst_n),
    .i_start  (wake_start),
    .i_use_cs (i_wake_use_cs),
    .i_opcode ((op_byte == `OBHD_UNPROG_BYTE) ? `OBHD_WAKE_DEFAULT : op_byte),
    .i_div    (hdr_reg[`OBHD_W_BOOTCFG][23:16]),
    .o_done   (wake_done),
    .o_sclk   (o_spi_sclk),
    .o_cs_n   (o_spi_cs_n),
    .o_mosi   (o_spi_mosi)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  read_addr_a: assert property (o_otp_rd |-> o_otp_addr >= `OBHD_HDR_BASE && // RL4
    o_otp_addr < `OBHD_HDR_BASE + 13'h000B) else $error("header read out of range");
  read_count_a: assert property (o_done && !$past(o_done) |->  // RL18
    idx_reg == `OBHD_READ_WORDS) else $error("wrong number of header words");
  mode_select_a: assert property (o_done |-> o_normal_mode == flags_ok // RL7
    && o_dev_mode == !flags_ok) else $error("mode does not follow flags");
  spi_boot_a: assert property (o_done |-> o_spi_boot == // RL8
    (boot_byte == `OBHD_BOOT_SPI)) else $error("serial boot decode wrong");
  uart_sel_a: assert property (o_done && uart_byte > 8'h02 |-> // RL10
    o_uart_sel == OBHD_UART_TWO_WIRE) else $error("unknown UART code not two-wire");
  wake_op_a: assert property (o_done && op_byte == 8'hFF |-> // RL21
    o_wake_opcode == 8'hAB) else $error("default wake opcode wrong");
  wake_gate_a: assert property (wake_start |-> o_spi_boot ##1 // RL20
    st_reg == OBHD_ST_WAKE) else $error("wake without serial boot");
  pkg_erased_a: assert property (o_done && hdr_reg[`OBHD_W_PKG] == 32'hFFFF_FFFF // RL19
    |-> o_pkg_unprog && o_pkg_type == OBHD_PKG_WAFER_L5) else $error("erased word missed");
  pin_map_a: assert property (o_done |-> o_boot_data_in_pin == pmap[27:24] // RL11
    && o_clk_port == pmap[7:4]) else $error("pin map nibble wrong");

endmodule : obhd_decoder

// ---- tb/obhd_otp_model.sv ----
// Word store model on the far side of the decoder's read port.
// Assumes one request at a time; answers after i_delay idle cycles.
`timescale 1ns/1ns

module obhd_otp_model (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Read port
  input  wire logic         i_rd,
  input  wire logic [12:0]  i_addr,
  output logic              o_valid,
  output logic [31:0]       o_data,
  // Control and status
  input  wire logic [351:0] i_image,
  input  wire logic [3:0]   i_delay,
  output logic [3:0]        o_reads,
  output logic              o_bad
);
  logic       pend_reg;
  logic [3:0] wait_reg;
  logic [3:0] idx_reg;

  // ------------------------------------------------------------
  // Store answer
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid  <= 1'b0;
      o_data   <= 32'h5A5A_5A5A;
      o_reads  <= 4'h0;
      o_bad    <= 1'b0;
      pend_reg <= 1'b0;
      wait_reg <= 4'h0;
      idx_reg  <= 4'h0;
    end else begin
      o_valid <= 1'b0;
      // Idle data line toggles so a stale word never looks valid
      o_data  <= ~o_data;
      if (i_rd) begin
        if (pend_reg || o_reads > 4'hA || i_addr !== 13'h1FF0 + 13'(o_reads)) begin
          o_bad <= 1'b1;
        end
        idx_reg  <= o_reads;
        o_reads  <= o_reads + 4'h1;
        pend_reg <= 1'b1;
        wait_reg <= i_delay;
      end else if (pend_reg) begin
        if (wait_reg == 4'h0) begin
          o_valid  <= 1'b1;
          o_data   <= (idx_reg > 4'hA) ? 32'hFFFF_FFFF : i_image[32*idx_reg +: 32];
          pend_reg <= 1'b0;
        end else begin
          wait_reg <= wait_reg - 4'h1;
        end
      end
    end
  end
endmodule : obhd_otp_model

// ---- tb/otp_boot_header_decoder_tb.sv ----
// Self-checking bench for the boot header decoder with a store model.
// Assumes the decoder starts its header read by itself after reset.
`timescale 1ns/1ns
`include "obhd_map.svh"

module otp_boot_header_decoder_tb
  import obhd_pkg::*;
;
  typedef struct packed {
    logic [31:0] f1, f2, cfg, pkw;
    logic        use_cs, nrm, spi;
    obhd_uart_t  uart;
    logic [7:0]  op;
    obhd_pkg_t   ptype;
    logic        unprog;
  } obhd_row_t;

  localparam logic [31:0] PMAP = 32'h7654_3210;
  localparam logic [31:0] ALO = 32'h0403_0201;
  localparam logic [31:0] AHI = 32'h0807_0605;
  localparam logic [31:0] COPY = 32'h0000_0100;
  localparam logic [31:0] POS = 32'hB4B3_B2B1;
  localparam logic [31:0] TST = 32'hC4C3_C2C1;
  localparam logic [31:0] STMP = 32'hD4D3_D2D1;

  logic i_clock = 1'b0, i_rst_n = 1'b0, i_wake_use_cs = 1'b0;
  logic o_otp_rd, i_otp_valid, o_done, o_normal_mode, o_dev_mode, o_spi_boot;
  logic o_probe_others, o_pkg_unprog, o_copy_len_ok, o_spi_sclk, o_spi_cs_n, o_spi_mosi;
  logic [12:0] o_otp_addr;
  logic [31:0] i_otp_data, o_copy_len, o_stamp;
  obhd_uart_t o_uart_sel;
  obhd_pkg_t o_pkg_type;
  logic [7:0] o_wake_opcode, o_spi_div, o_device_code, o_die_x, o_die_y, o_wafer;
  logic [7:0] o_production_batch, o_test_site;
  logic [3:0] o_clk_port, o_clk_pin, o_sel_port, o_sel_pin, o_dout_port, o_dout_pin;
  logic [3:0] o_boot_data_in_pin_port, o_boot_data_in_pin, delay = 4'h0, reads;
  logic [15:0] o_test_station_ident;
  logic [63:0] o_radio_addr;
  logic [351:0] image = '0;
  logic bad;
  logic [7:0] cap;
  int fails = 0, checks = 0, nbits = 0, nlow = 0, nb0, nl0;
  time t_last, per;
  obhd_row_t rows [6];

  obhd_decoder dut (.*);
  obhd_otp_model store (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rd(o_otp_rd),
    .i_addr(o_otp_addr), .o_valid(i_otp_valid), .o_data(i_otp_data), .i_image(image),
    .i_delay(delay), .o_reads(reads), .o_bad(bad));

  initial begin
    forever #10 i_clock = ~i_clock;
  end

  // ------------------------------------------------------------
  // Wake line monitor, byte sampled on sclk rise
  // ------------------------------------------------------------
  always @(posedge o_spi_sclk) begin
    cap = {cap[6:0], o_spi_mosi};
    nbits++;
    per = $time - t_last;
    t_last = $time;
  end
  always @(negedge o_spi_cs_n) nlow++;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // Cut: cycles after release before a second reset, zero for none
  task automatic boot(input obhd_row_t r, input logic [3:0] dly, input int cut);
    @(negedge i_clock);
    image = {STMP, TST, POS, COPY, AHI, ALO, r.pkw, PMAP, r.cfg, r.f2, r.f1};
    delay = dly;
    i_wake_use_cs = r.use_cs;
    i_rst_n = 1'b0;
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'b1;
    if (cut > 0) begin
      repeat (cut) @(negedge i_clock);
      i_rst_n = 1'b0;
      @(negedge i_clock);
      chk(o_otp_rd, 1'b0);
      chk({o_done, o_spi_cs_n, o_spi_sclk}, 3'b010);
      repeat (3) @(negedge i_clock);
      i_rst_n = 1'b1;
    end
    // Counters belong to the monitor; take a baseline instead of clearing them
    nb0 = nbits;
    nl0 = nlow;
    for (int k = 0; k < 3000 && o_done !== 1'b1; k++) @(negedge i_clock);
    if (o_done !== 1'b1) begin
      $display("mismatch t=%0t done timeout got=%h exp=%h", $time, 1'b0, 1'b1);
      fails++;
      test_done();
    end
  endtask : boot

  task automatic check_row(input obhd_row_t r);
    chk(o_normal_mode, r.nrm);
    chk(o_dev_mode, !r.nrm);
    chk(o_spi_boot, r.spi);
    chk(o_probe_others, !r.spi);
    chk(o_uart_sel, r.uart);
    chk(o_wake_opcode, r.op);
    chk(o_spi_div, r.cfg[23:16]);
    chk({o_device_code, o_pkg_type}, {r.pkw[15:8], r.ptype});
    chk(o_pkg_unprog, r.unprog);
    chk({o_spi_cs_n, o_spi_sclk}, 2'b10);
    if (r.spi && !r.use_cs) begin
      chk({cap, 8'(nbits - nb0), 8'(nlow - nl0)}, {r.op, 8'h08, 8'h01});
      chk(per, 40 * (r.cfg[23:16] + 1));
    end
    if (r.spi && r.use_cs) chk({8'(nbits - nb0), 8'(nlow - nl0)}, 16'h0001);
    if (!r.spi) chk(nlow - nl0, 0);
    chk({reads, bad}, {4'hB, 1'b0});
    chk({o_boot_data_in_pin_port, o_boot_data_in_pin, o_dout_port, o_dout_pin,
      o_sel_port, o_sel_pin, o_clk_port, o_clk_pin}, PMAP);
    chk(o_radio_addr, {AHI, ALO});
    chk(o_copy_len, COPY);
    chk(o_copy_len_ok, 1'b1);
    chk({o_production_batch, o_wafer, o_die_y, o_die_x}, POS);
    chk({o_test_station_ident, o_test_site}, TST[23:0]);
    chk(o_stamp, STMP);
  endtask : check_row

  // ------------------------------------------------------------
  // Table of ordinary cases, then slow store and mid-run reset
  // ------------------------------------------------------------
  initial begin
    rows[0] = '{`OBHD_FLAG1_VALID, `OBHD_FLAG2_VALID, 32'h0001_ABFF, 32'hFFFF_FFFF,
      1'b0, 1'b1, 1'b0, OBHD_UART_TWO_WIRE, 8'hAB, OBHD_PKG_WAFER_L5, 1'b1};
    rows[1] = '{32'h1234_A5A4, `OBHD_FLAG2_VALID, 32'h0101_9FAA, 32'h0000_0066,
      1'b0, 1'b0, 1'b1, OBHD_UART_ONE_WIRE_L3, 8'h9F, OBHD_PKG_WAFER_NO_L5, 1'b0};
    rows[2] = '{`OBHD_FLAG1_VALID, 32'hA5A5_1235, 32'h0203_FFAA, 32'h0000_3CAA,
      1'b0, 1'b0, 1'b1, OBHD_UART_ONE_WIRE_L5, 8'hAB, OBHD_PKG_QUAD_FLAT, 1'b0};
    rows[3] = '{`OBHD_FLAG1_VALID, `OBHD_FLAG2_VALID, 32'h0301_05AA, 32'h0000_1212,
      1'b1, 1'b1, 1'b1, OBHD_UART_TWO_WIRE, 8'h05, OBHD_PKG_OTHER, 1'b0};
    rows[4] = '{`OBHD_FLAG1_VALID, `OBHD_FLAG2_VALID, 32'hFF00_0055, 32'h0FFF_FFFF,
      1'b0, 1'b1, 1'b0, OBHD_UART_TWO_WIRE, 8'h00, OBHD_PKG_WAFER_L5, 1'b1};
    rows[5] = '{`OBHD_FLAG2_VALID, `OBHD_FLAG1_VALID, 32'h0001_ABFF, 32'h0000_5566,
      1'b0, 1'b0, 1'b0, OBHD_UART_TWO_WIRE, 8'hAB, OBHD_PKG_WAFER_NO_L5, 1'b0};
    for (int i = 0; i < 6; i++) begin
      boot(rows[i], 4'h0, 0);
      check_row(rows[i]);
      $display("row %0d done", i);
    end
    boot(rows[2], 4'h6, 0);
    check_row(rows[2]);
    $display("slow store done");
    boot(rows[3], 4'h1, 9);
    check_row(rows[3]);
    $display("mid-run reset done");
    test_done();
  end
endmodule : otp_boot_header_decoder_tb
